// [isc_regs.svh]
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH

// Register offsets
`define ISC_OFS_SEQUENCER_CONFIG    4'h0
`define ISC_OFS_PIXEL_PAIR_COUNT    4'h1
`define ISC_OFS_LINE_COUNT          4'h2
`define ISC_OFS_INTEGRATION_COUNT   4'h3
`define ISC_OFS_COLUMN_WINDOW_START 4'h4
`define ISC_OFS_READ_ROW_START      4'h5
`define ISC_OFS_RESET_ROW_START     4'h6
`define ISC_OFS_ARRAY_TEST_SUBSAMP  4'h7
`define ISC_OFS_OUTPUT_AMP_CONTROL  4'h8
`define ISC_OFS_COARSE_OFFSET       4'h9
`define ISC_OFS_FINE_OFFSET         4'hA
`define ISC_OFS_CONVERTER_CONTROL   4'hB

// Reset values
`define ISC_RST_SEQUENCER_CONFIG    12'h0C4
`define ISC_RST_PIXEL_PAIR_COUNT    12'h27F
`define ISC_RST_LINE_COUNT          12'h3FF
`define ISC_RST_INTEGRATION_COUNT   12'h7FF
`define ISC_RST_COLUMN_WINDOW_START 11'h000
`define ISC_RST_ROW_START           11'h000
`define ISC_RST_ARRAY_TEST_SUBSAMP  8'h00
`define ISC_RST_OUTPUT_AMP_CONTROL  7'h50
`define ISC_RST_OFFSET              7'h40
`define ISC_RST_CONVERTER_CONTROL   3'h3

// Upper limit for pixel pair count and column start (half of 1280)
`define ISC_COLUMN_LIMIT            12'h280

// Sequencer configuration fields
`define ISC_SEQ_SHUTTER_ROLLING     0
`define ISC_SEQ_FRAME_CAL_SLOW      1
`define ISC_SEQ_LINE_CAL_SLOW       2
`define ISC_SEQ_CONT_FEED           3
`define ISC_SEQ_ROW_DIV_LO          4
`define ISC_SEQ_SNAP_DIV_LO         6
`define ISC_SEQ_SLOPE_LVL_LO        8
`define ISC_SEQ_MULTI_SLOPE         10
`define ISC_SEQ_EXT_RESET_LEVEL     11

// Divider bases in system clocks
`define ISC_ROW_DIV_BASE            8'h04
`define ISC_SNAP_DIV_BASE           8'h20

// Row blanking: 3.5 us at the reference 25 ns pixel clock, counted in
// row sequencer ticks of the smallest divider
`define ISC_ROW_BLANK_NS            3500
`define ISC_REF_PERIOD_NS           25
`define ISC_ROW_BLANK_TICKS         (`ISC_ROW_BLANK_NS / (`ISC_REF_PERIOD_NS * 4))

`endif

// [isc_pkg.sv]
package isc_pkg;

	typedef enum logic [1:0] {
		ISC_ROW_IDLE,
		ISC_ROW_BLANK,
		ISC_ROW_READ
	} isc_row_e;

	typedef logic [11:0] isc_word_t;

endpackage

// [isc_config_bank.sv]
`timescale 1ns/1ps
`include "isc_regs.svh"

module isc_config_bank (
	// Clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Parallel configuration pins
	input  wire logic [3:0]  cfg_addr,
	input  wire logic [11:0] cfg_data,
	input  wire logic        cfg_load,
	input  wire logic [3:0]  cfg_rd_addr,
	output logic      [11:0] cfg_rd_data,
	// Sequencer pulses from the controller
	input  wire logic        frame_start,
	input  wire logic        row_clock,
	// Shutter and calibration
	output logic             shutter_rolling,
	output logic             cal_slow,
	output logic             cal_strobe,
	output logic             column_continuous_feed,
	output logic             column_precharge,
	// Sequencer clocks and readout
	output logic             row_seq_tick,
	output logic             snap_seq_tick,
	output logic             row_blank,
	output logic             pixel_valid,
	output logic             column_shift_en,
	output logic             odd_bus_sel,
	// Multiple slope
	output logic [1:0]       slope_level,
	output logic             multi_slope_on,
	output logic             external_reset_level,
	output logic             right_reset_supply_en,
	// Window
	output logic [11:0]      pixel_pair_count,
	output logic [11:0]      line_count,
	output logic [11:0]      integration_count,
	output logic [10:0]      column_window_start,
	output logic [10:0]      read_row_start,
	output logic [10:0]      reset_row_start,
	// Image core
	output logic             test_even,
	output logic             test_odd,
	output logic             column_decimate,
	output logic             column_pair_swap_a,
	output logic             column_pair_swap_b,
	output logic             row_decimate,
	output logic             row_pair_swap_a,
	output logic             row_pair_swap_b,
	// Amplifier and converter
	output logic [3:0]       amp_gain,
	output logic             amp_unity,
	output logic             amp_dual_out,
	output logic             amp_active,
	output logic [6:0]       coarse_offset,
	output logic [6:0]       fine_offset,
	output logic             output_bus_drive,
	output logic             gamma_on,
	output logic             output_invert
);

	// Pin synchronisers, first stage read only by second
	logic [3:0]  addr_s1_reg, addr_s2_reg;
	logic [11:0] data_s1_reg, data_s2_reg;
	logic [3:0]  rd_addr_s1_reg, rd_addr_s2_reg;
	logic [2:0]  load_sync_reg;
	logic [2:0]  frame_sync_reg;
	logic [2:0]  row_sync_reg;
	logic        wr_pulse;
	logic        frame_pulse;
	logic        row_pulse;

	always_ff @(posedge mclk) begin
		if (rst) begin
			addr_s1_reg    <= 4'h0;
			addr_s2_reg    <= 4'h0;
			data_s1_reg    <= 12'h000;
			data_s2_reg    <= 12'h000;
			rd_addr_s1_reg <= 4'h0;
			rd_addr_s2_reg <= 4'h0;
			load_sync_reg  <= 3'h0;
			frame_sync_reg <= 3'h0;
			row_sync_reg   <= 3'h0;
		end else if (ce) begin
			addr_s1_reg    <= cfg_addr;
			addr_s2_reg    <= addr_s1_reg;
			data_s1_reg    <= cfg_data;
			data_s2_reg    <= data_s1_reg;
			rd_addr_s1_reg <= cfg_rd_addr;
			rd_addr_s2_reg <= rd_addr_s1_reg;
			load_sync_reg  <= {load_sync_reg[1:0], cfg_load};
			frame_sync_reg <= {frame_sync_reg[1:0], frame_start};
			row_sync_reg   <= {row_sync_reg[1:0], row_clock};
		end
	end

	// Rising edges, taken from stages two and three only
	assign wr_pulse    = ce & load_sync_reg[1] & ~load_sync_reg[2];
	assign frame_pulse = ce & frame_sync_reg[1] & ~frame_sync_reg[2];
	assign row_pulse   = ce & row_sync_reg[1] & ~row_sync_reg[2];

	// Register file
	logic [11:0] sequencer_config_reg;
	logic [11:0] pixel_pair_count_reg;
	logic [11:0] line_count_reg;
	logic [11:0] integration_count_reg;
	logic [10:0] column_window_start_reg;
	logic [10:0] read_row_start_reg;
	logic [10:0] reset_row_start_reg;
	logic [7:0]  array_test_subsample_reg;
	logic [6:0]  output_amp_control_reg;
	logic [6:0]  coarse_offset_reg;
	logic [6:0]  fine_offset_reg;
	logic [2:0]  converter_control_reg;
	logic [11:0] pair_next;
	logic [11:0] col_start_next;

	// Values above half the array width are held at the limit
	assign pair_next      = (data_s2_reg > `ISC_COLUMN_LIMIT) ? `ISC_COLUMN_LIMIT : data_s2_reg;
	assign col_start_next = (data_s2_reg > `ISC_COLUMN_LIMIT) ? `ISC_COLUMN_LIMIT : data_s2_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sequencer_config_reg     <= `ISC_RST_SEQUENCER_CONFIG;
			pixel_pair_count_reg     <= `ISC_RST_PIXEL_PAIR_COUNT;
			line_count_reg           <= `ISC_RST_LINE_COUNT;
			integration_count_reg    <= `ISC_RST_INTEGRATION_COUNT;
			column_window_start_reg  <= `ISC_RST_COLUMN_WINDOW_START;
			read_row_start_reg       <= `ISC_RST_ROW_START;
			reset_row_start_reg      <= `ISC_RST_ROW_START;
			array_test_subsample_reg <= `ISC_RST_ARRAY_TEST_SUBSAMP;
			output_amp_control_reg   <= `ISC_RST_OUTPUT_AMP_CONTROL;
			coarse_offset_reg        <= `ISC_RST_OFFSET;
			fine_offset_reg          <= `ISC_RST_OFFSET;
			converter_control_reg    <= `ISC_RST_CONVERTER_CONTROL;
		end else if (wr_pulse) begin
			case (addr_s2_reg)
				`ISC_OFS_SEQUENCER_CONFIG: begin
					sequencer_config_reg <= data_s2_reg;
				end
				`ISC_OFS_PIXEL_PAIR_COUNT: begin
					pixel_pair_count_reg <= pair_next;
				end
				`ISC_OFS_LINE_COUNT: begin
					line_count_reg <= data_s2_reg;
				end
				`ISC_OFS_INTEGRATION_COUNT: begin
					integration_count_reg <= data_s2_reg;
				end
				`ISC_OFS_COLUMN_WINDOW_START: begin
					column_window_start_reg <= col_start_next[10:0];
				end
				`ISC_OFS_READ_ROW_START: begin
					read_row_start_reg <= data_s2_reg[10:0];
				end
				`ISC_OFS_RESET_ROW_START: begin
					reset_row_start_reg <= data_s2_reg[10:0];
				end
				`ISC_OFS_ARRAY_TEST_SUBSAMP: begin
					array_test_subsample_reg <= data_s2_reg[7:0];
				end
				`ISC_OFS_OUTPUT_AMP_CONTROL: begin
					output_amp_control_reg <= data_s2_reg[6:0];
				end
				`ISC_OFS_COARSE_OFFSET: begin
					coarse_offset_reg <= data_s2_reg[6:0];
				end
				`ISC_OFS_FINE_OFFSET: begin
					fine_offset_reg <= data_s2_reg[6:0];
				end
				`ISC_OFS_CONVERTER_CONTROL: begin
					converter_control_reg <= data_s2_reg[2:0];
				end
				default: begin
					// Reserved offsets take no write
				end
			endcase
		end
	end

	// Read back, registered; narrow registers zero-extended
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_rd_data <= 12'h000;
		end else if (ce) begin
			case (rd_addr_s2_reg)
				`ISC_OFS_SEQUENCER_CONFIG:    cfg_rd_data <= sequencer_config_reg;
				`ISC_OFS_PIXEL_PAIR_COUNT:    cfg_rd_data <= pixel_pair_count_reg;
				`ISC_OFS_LINE_COUNT:          cfg_rd_data <= line_count_reg;
				`ISC_OFS_INTEGRATION_COUNT:   cfg_rd_data <= integration_count_reg;
				`ISC_OFS_COLUMN_WINDOW_START: cfg_rd_data <= {1'b0, column_window_start_reg};
				`ISC_OFS_READ_ROW_START:      cfg_rd_data <= {1'b0, read_row_start_reg};
				`ISC_OFS_RESET_ROW_START:     cfg_rd_data <= {1'b0, reset_row_start_reg};
				`ISC_OFS_ARRAY_TEST_SUBSAMP:  cfg_rd_data <= {4'h0, array_test_subsample_reg};
				`ISC_OFS_OUTPUT_AMP_CONTROL:  cfg_rd_data <= {5'h00, output_amp_control_reg};
				`ISC_OFS_COARSE_OFFSET:       cfg_rd_data <= {5'h00, coarse_offset_reg};
				`ISC_OFS_FINE_OFFSET:         cfg_rd_data <= {5'h00, fine_offset_reg};
				`ISC_OFS_CONVERTER_CONTROL:   cfg_rd_data <= {9'h000, converter_control_reg};
				default:                      cfg_rd_data <= 12'h000;
			endcase
		end
	end

	// Field outputs
	logic [1:0] row_div_sel;
	logic [1:0] snap_div_sel;

	assign row_div_sel  = sequencer_config_reg[`ISC_SEQ_ROW_DIV_LO +: 2];
	assign snap_div_sel = sequencer_config_reg[`ISC_SEQ_SNAP_DIV_LO +: 2];

	assign shutter_rolling        = sequencer_config_reg[`ISC_SEQ_SHUTTER_ROLLING];
	assign column_continuous_feed = sequencer_config_reg[`ISC_SEQ_CONT_FEED];
	assign slope_level            = sequencer_config_reg[`ISC_SEQ_SLOPE_LVL_LO +: 2];
	// Multiple slope only acts in snapshot mode
	assign multi_slope_on         = sequencer_config_reg[`ISC_SEQ_MULTI_SLOPE] & ~shutter_rolling;
	assign external_reset_level   = sequencer_config_reg[`ISC_SEQ_EXT_RESET_LEVEL];
	assign right_reset_supply_en  = ~sequencer_config_reg[`ISC_SEQ_EXT_RESET_LEVEL];

	assign pixel_pair_count    = pixel_pair_count_reg;
	assign line_count          = line_count_reg;
	assign integration_count   = integration_count_reg;
	assign column_window_start = column_window_start_reg;
	assign read_row_start      = read_row_start_reg;
	assign reset_row_start     = reset_row_start_reg;

	assign test_even          = array_test_subsample_reg[0];
	assign test_odd           = array_test_subsample_reg[1];
	assign column_decimate    = array_test_subsample_reg[2];
	assign column_pair_swap_a = array_test_subsample_reg[3];
	assign column_pair_swap_b = array_test_subsample_reg[4];
	assign row_decimate       = array_test_subsample_reg[5];
	assign row_pair_swap_a    = array_test_subsample_reg[6];
	assign row_pair_swap_b    = array_test_subsample_reg[7];

	assign amp_gain     = output_amp_control_reg[3:0];
	assign amp_unity    = output_amp_control_reg[4];
	assign amp_dual_out = output_amp_control_reg[5];
	assign amp_active   = output_amp_control_reg[6];
	assign coarse_offset = coarse_offset_reg;
	assign fine_offset   = fine_offset_reg;

	assign output_bus_drive = converter_control_reg[0];
	assign gamma_on         = ~converter_control_reg[1];
	assign output_invert    = converter_control_reg[2];

	// Sequencer clock dividers from one free-running count
	logic [7:0] div_cnt_reg;
	logic [7:0] row_mask;
	logic [7:0] snap_mask;

	assign row_mask  = 8'((`ISC_ROW_DIV_BASE << row_div_sel) - 8'h01);
	assign snap_mask = 8'((`ISC_SNAP_DIV_BASE << snap_div_sel) - 8'h01);

	always_ff @(posedge mclk) begin
		if (rst) begin
			div_cnt_reg <= 8'h00;
		end else if (ce) begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end

	assign row_seq_tick  = ce & ((div_cnt_reg & row_mask) == row_mask);
	assign snap_seq_tick = ce & ((div_cnt_reg & snap_mask) == snap_mask);

	// Calibration mode: frame setting on the first row, line setting after
	logic first_row_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			first_row_reg <= 1'b1;
			cal_slow      <= 1'b0;
		end else if (frame_pulse) begin
			first_row_reg <= 1'b1;
			cal_slow      <= sequencer_config_reg[`ISC_SEQ_FRAME_CAL_SLOW];
		end else if (row_pulse) begin
			first_row_reg <= 1'b0;
			if (!first_row_reg) begin
				cal_slow <= sequencer_config_reg[`ISC_SEQ_LINE_CAL_SLOW];
			end
		end
	end

	// Row sequence: blanking measured in row ticks, then readout at pixel rate
	isc_pkg::isc_row_e row_state_reg;
	logic [7:0]        blank_cnt_reg;
	logic [11:0]       pair_cnt_reg;
	logic              phase_reg;

	always_ff @(posedge mclk) begin
		if (rst) begin
			row_state_reg <= isc_pkg::ISC_ROW_IDLE;
			blank_cnt_reg <= 8'h00;
			pair_cnt_reg  <= 12'h000;
			phase_reg     <= 1'b0;
		end else if (ce) begin
			if (row_pulse) begin
				row_state_reg <= isc_pkg::ISC_ROW_BLANK;
				blank_cnt_reg <= 8'h00;
				pair_cnt_reg  <= 12'h000;
				phase_reg     <= 1'b0;
			end else begin
				case (row_state_reg)
					isc_pkg::ISC_ROW_BLANK: begin
						// Slower row clock lengthens only this phase
						if (row_seq_tick) begin
							if (blank_cnt_reg == 8'(`ISC_ROW_BLANK_TICKS - 1)) begin
								row_state_reg <= isc_pkg::ISC_ROW_READ;
							end
							blank_cnt_reg <= blank_cnt_reg + 8'h01;
						end
					end
					isc_pkg::ISC_ROW_READ: begin
						// Two pixels per column shift, one per clock
						phase_reg <= ~phase_reg;
						if (phase_reg) begin
							if (pair_cnt_reg == pixel_pair_count_reg) begin
								row_state_reg <= isc_pkg::ISC_ROW_IDLE;
							end
							pair_cnt_reg <= pair_cnt_reg + 12'h001;
						end
					end
					default: begin
						row_state_reg <= isc_pkg::ISC_ROW_IDLE;
					end
				endcase
			end
		end
	end

	assign row_blank       = (row_state_reg == isc_pkg::ISC_ROW_BLANK);
	assign pixel_valid     = (row_state_reg == isc_pkg::ISC_ROW_READ);
	assign column_shift_en = pixel_valid & phase_reg;
	assign odd_bus_sel     = pixel_valid & phase_reg;

	// Calibration requested once per row blanking, precharge too unless continuous feed is set
	always_ff @(posedge mclk) begin
		if (rst) begin
			cal_strobe       <= 1'b0;
			column_precharge <= 1'b0;
		end else if (ce) begin
			cal_strobe       <= row_pulse;
			column_precharge <= row_pulse & ~sequencer_config_reg[`ISC_SEQ_CONT_FEED];
		end
	end

endmodule

// [isc_config_bank_props.sv]
`timescale 1ns/1ps
module isc_config_bank_props (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        ce,
	// Observed outputs
	input wire logic        shutter_rolling,
	input wire logic        cal_strobe,
	input wire logic        column_continuous_feed,
	input wire logic        column_precharge,
	input wire logic        row_seq_tick,
	input wire logic        snap_seq_tick,
	input wire logic        row_blank,
	input wire logic        pixel_valid,
	input wire logic        column_shift_en,
	input wire logic        odd_bus_sel,
	input wire logic        multi_slope_on,
	input wire logic        external_reset_level,
	input wire logic        right_reset_supply_en,
	input wire logic [11:0] pixel_pair_count
);
	logic [7:0]  snap_gap;
	logic        snap_seen;
	logic [12:0] valid_cnt;
	logic [6:0]  blank_ticks;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	always_ff @(posedge mclk) begin
		if (rst || snap_seq_tick) begin
			snap_gap <= 8'h00;
		end else if (ce && snap_gap != 8'hFF) begin
			snap_gap <= snap_gap + 8'h01;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			snap_seen <= 1'b0;
		end else if (snap_seq_tick) begin
			snap_seen <= 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst || !pixel_valid) begin
			valid_cnt <= 13'h0000;
		end else if (ce) begin
			valid_cnt <= valid_cnt + 13'h0001;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst || !row_blank) begin
			blank_ticks <= 7'h00;
		end else if (row_seq_tick) begin
			blank_ticks <= blank_ticks + 7'h01;
		end
	end

	sequence first_half_s;
		pixel_valid && !column_shift_en;
	endsequence
	sequence read_end_s;
		!pixel_valid && !row_blank && valid_cnt != 13'h0000;
	endsequence

	slope_mode_a: assert property (multi_slope_on |-> !shutter_rolling)
		else $error("multi slope active in rolling mode");
	reset_supply_a: assert property (right_reset_supply_en != external_reset_level)
		else $error("right reset supply not opposite to external select");
	precharge_pulse_a: assert property (column_precharge |-> cal_strobe && !column_continuous_feed)
		else $error("precharge without strobe or under continuous feed");
	strobe_single_a: assert property (cal_strobe |-> row_blank ##1 !cal_strobe)
		else $error("calibration strobe outside blanking or too long");
	row_tick_gap_a: assert property (row_seq_tick |=> !row_seq_tick [*3])
		else $error("row ticks closer than four cycles");
	snap_tick_gap_a: assert property (snap_seq_tick && snap_seen |-> snap_gap[4:0] == 5'h1F)
		else $error("snapshot tick spacing not a multiple of 32");
	blank_then_read_a: assert property ($fell(row_blank) |-> pixel_valid && blank_ticks inside {[34:36]})
		else $error("blanking length wrong or readout missing");
	read_not_blank_a: assert property (pixel_valid |-> !row_blank)
		else $error("pixel valid during blanking");
	pair_merge_a: assert property (first_half_s ##1 pixel_valid |-> column_shift_en && odd_bus_sel)
		else $error("second pixel of pair not on odd bus");
	pair_count_a: assert property (read_end_s |-> valid_cnt == {pixel_pair_count, 1'b0} + 13'h0002)
		else $error("readout length differs from pair count");
endmodule

bind isc_config_bank isc_config_bank_props isc_config_bank_props_inst (
	.mclk, .rst, .ce, .shutter_rolling, .cal_strobe, .column_continuous_feed, .column_precharge,
	.row_seq_tick, .snap_seq_tick, .row_blank, .pixel_valid, .column_shift_en, .odd_bus_sel,
	.multi_slope_on, .external_reset_level, .right_reset_supply_en, .pixel_pair_count
);

// [isc_ctrl_model.sv]
`timescale 1ns/1ps
module isc_ctrl_model (
	// Clock
	input  wire logic        mclk,
	// Configuration and sequencer pins
	output logic      [3:0]  cfg_addr,
	output logic      [11:0] cfg_data,
	output logic             cfg_load,
	output logic             frame_start,
	output logic             row_clock
);
	initial begin
		cfg_addr = 4'h0;
		cfg_data = 12'h000;
		cfg_load = 1'b0;
		frame_start = 1'b0;
		row_clock = 1'b0;
	end

	// Registers are loaded only over the parallel pins
	task automatic write_reg(input logic [3:0] a, input logic [11:0] d);
		@(posedge mclk);
		cfg_addr <= a;
		cfg_data <= d;
		@(posedge mclk);
		cfg_load <= 1'b1;
		repeat (4) @(posedge mclk);
		cfg_load <= 1'b0;
		// Released bus shows a changed pattern, never the old value
		cfg_addr <= ~a;
		cfg_data <= ~d;
		repeat (3) @(posedge mclk);
	endtask

	task automatic pulse(input logic frame);
		@(posedge mclk);
		if (frame) begin
			frame_start <= 1'b1;
		end else begin
			row_clock <= 1'b1;
		end
		repeat (3) @(posedge mclk);
		frame_start <= 1'b0;
		row_clock <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
endmodule

// [isc_config_bank_tb.sv]
`timescale 1ns/1ps
module isc_config_bank_tb;
	logic        mclk, rst, ce, cfg_load, frame_start, row_clock, rd_go;
	logic [3:0]  cfg_addr, cfg_rd_addr;
	logic [11:0] cfg_data, cfg_rd_data, d;
	logic        shutter_rolling, cal_slow, cal_strobe, column_continuous_feed, column_precharge;
	logic        row_seq_tick, snap_seq_tick, row_blank, pixel_valid, column_shift_en, odd_bus_sel;
	logic [1:0]  slope_level;
	logic        multi_slope_on, external_reset_level, right_reset_supply_en;
	logic [11:0] pixel_pair_count, line_count, integration_count;
	logic [10:0] column_window_start, read_row_start, reset_row_start;
	logic        test_even, test_odd, column_decimate, column_pair_swap_a, column_pair_swap_b;
	logic        row_decimate, row_pair_swap_a, row_pair_swap_b;
	logic [3:0]  amp_gain;
	logic        amp_unity, amp_dual_out, amp_active, output_bus_drive, gamma_on, output_invert;
	logic [6:0]  coarse_offset, fine_offset;
	logic [15:0] seed;
	logic [11:0] exp_q[$];
	logic [11:0] rst_val[16] = '{12'h0C4, 12'h27F, 12'h3FF, 12'h7FF, 12'h000, 12'h000, 12'h000, 12'h000,
		12'h050, 12'h040, 12'h040, 12'h003, 12'h000, 12'h000, 12'h000, 12'h000};
	int          n_errors, check_count, n_strobe, n_pre, n_valid, a;

	isc_config_bank isc_config_bank_inst (.mclk, .rst, .ce, .cfg_addr, .cfg_data, .cfg_load, .cfg_rd_addr,
		.cfg_rd_data, .frame_start, .row_clock, .shutter_rolling, .cal_slow, .cal_strobe,
		.column_continuous_feed, .column_precharge, .row_seq_tick, .snap_seq_tick, .row_blank, .pixel_valid,
		.column_shift_en, .odd_bus_sel, .slope_level, .multi_slope_on, .external_reset_level,
		.right_reset_supply_en, .pixel_pair_count, .line_count, .integration_count, .column_window_start,
		.read_row_start, .reset_row_start, .test_even, .test_odd, .column_decimate, .column_pair_swap_a,
		.column_pair_swap_b, .row_decimate, .row_pair_swap_a, .row_pair_swap_b, .amp_gain, .amp_unity,
		.amp_dual_out, .amp_active, .coarse_offset, .fine_offset, .output_bus_drive, .gamma_on, .output_invert);
	isc_ctrl_model isc_ctrl_model_inst (.mclk, .cfg_addr, .cfg_data, .cfg_load, .frame_start, .row_clock);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic done(input string t);
		$display("test %s finished", t);
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [11:0] expect_rd(input logic [3:0] ad, input logic [11:0] dd);
		logic [11:0] m;
		case (ad)
			4'h0, 4'h1, 4'h2, 4'h3: m = dd;
			4'h4, 4'h5, 4'h6: m = dd & 12'h7FF;
			4'h7: m = dd & 12'h0FF;
			4'h8, 4'h9, 4'hA: m = dd & 12'h07F;
			4'hB: m = dd & 12'h007;
			default: m = 12'h000;
		endcase
		// Clamp acts on the whole written word, before narrow registers drop bits
		if ((ad == 4'h1 || ad == 4'h4) && dd > 12'h280) m = 12'h280;
		return m;
	endfunction
	function automatic logic tick(input logic s);
		return s ? snap_seq_tick : row_seq_tick;
	endfunction

	task automatic read_reg(input logic [3:0] ad, input logic [11:0] exp);
		@(posedge mclk);
		cfg_rd_addr <= ad;
		repeat (4) @(posedge mclk);
		exp_q.push_back(exp);
		rd_go <= 1'b1;
		@(posedge mclk);
		rd_go <= 1'b0;
	endtask
	always @(posedge mclk) begin
		if (rd_go === 1'b1 && exp_q.size() > 0) check("read data", cfg_rd_data, exp_q.pop_front());
		if (cal_strobe === 1'b1) n_strobe++;
		if (column_precharge === 1'b1) n_pre++;
		if (pixel_valid === 1'b1) n_valid++;
	end

	task automatic gap(input logic s, input logic [11:0] exp);
		int i, g;
		repeat (2) begin
			for (i = 0; i < 600 && tick(s) !== 1'b1; i++) @(negedge mclk);
			@(negedge mclk);
			for (g = 1; g < 600 && tick(s) !== 1'b1; g++) @(negedge mclk);
		end
		check("tick gap", g[11:0], exp);
		if (g >= 600) close_out();
	endtask
	task automatic run_row(input logic [11:0] exp_pre, input logic exp_cal);
		int i;
		n_strobe = 0;
		n_pre = 0;
		n_valid = 0;
		isc_ctrl_model_inst.pulse(1'b0);
		for (i = 0; i < 3000 && !(n_valid > 0 && pixel_valid === 1'b0); i++) @(posedge mclk);
		if (i == 3000) begin
			n_errors++;
			close_out();
		end
		check("strobes", n_strobe[11:0], 12'h001);
		check("precharge", n_pre[11:0], exp_pre);
		check("cal mode", {11'h000, cal_slow}, {11'h000, exp_cal});
		check("pixels", n_valid[11:0], 12'h008);
	endtask

	initial begin
		#4000000;
		n_errors++;
		close_out();
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		cfg_rd_addr = 4'h0;
		rd_go = 1'b0;
		seed = 16'hC302;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		for (a = 0; a < 16; a++) read_reg(a[3:0], rst_val[a]);
		check("amp fields", {amp_active, amp_dual_out, amp_unity, amp_gain}, 12'h050);
		check("adc fields", {output_invert, gamma_on, output_bus_drive}, 12'h001);
		check("pair count out", pixel_pair_count, 12'h27F);
		check("line count out", line_count, 12'h3FF);
		check("int count out", integration_count, 12'h7FF);
		check("col start out", {1'b0, column_window_start}, 12'h000);
		check("row starts out", {1'b0, read_row_start | reset_row_start}, 12'h000);
		check("coarse out", {5'h00, coarse_offset}, 12'h040);
		check("fine out", {5'h00, fine_offset}, 12'h040);
		done("reset");
		for (a = 0; a < 16; a++) begin
			seed = lfsr(seed);
			isc_ctrl_model_inst.write_reg(a[3:0], seed[11:0]);
			read_reg(a[3:0], expect_rd(a[3:0], seed[11:0]));
		end
		isc_ctrl_model_inst.write_reg(4'h1, 12'hFFF);
		read_reg(4'h1, 12'h280);
		isc_ctrl_model_inst.write_reg(4'h4, 12'h7FF);
		read_reg(4'h4, 12'h280);
		done("readback");
		for (a = 0; a < 4; a++) begin
			seed = lfsr(seed);
			d = seed[11:0];
			isc_ctrl_model_inst.write_reg(4'h0, d);
			isc_ctrl_model_inst.write_reg(4'h7, d);
			isc_ctrl_model_inst.write_reg(4'h8, d);
			isc_ctrl_model_inst.write_reg(4'hB, d);
			check("seq fields", {external_reset_level, right_reset_supply_en, multi_slope_on, slope_level,
				column_continuous_feed, shutter_rolling}, {d[11], ~d[11], d[10] & ~d[0], d[9:8], d[3], d[0]});
			check("core fields", {row_pair_swap_b, row_pair_swap_a, row_decimate, column_pair_swap_b,
				column_pair_swap_a, column_decimate, test_odd, test_even}, d[7:0]);
			check("amp fields", {amp_active, amp_dual_out, amp_unity, amp_gain}, d[6:0]);
			check("adc fields", {output_invert, gamma_on, output_bus_drive}, {d[2], ~d[1], d[0]});
		end
		done("fields");
		// Last pass leaves the longest snapshot granularity in place
		for (a = 0; a < 4; a++) begin
			isc_ctrl_model_inst.write_reg(4'h0, {4'h0, a[1:0], a[1:0], 4'h0});
			gap(1'b0, 12'h004 << a);
			gap(1'b1, 12'h020 << a);
		end
		done("dividers");
		isc_ctrl_model_inst.write_reg(4'h1, 12'h003);
		isc_ctrl_model_inst.write_reg(4'h0, 12'h0C2);
		isc_ctrl_model_inst.pulse(1'b1);
		check("frame cal", {11'h000, cal_slow}, 12'h001);
		run_row(12'h001, 1'b1);
		run_row(12'h001, 1'b0);
		isc_ctrl_model_inst.write_reg(4'h0, 12'h0FA);
		run_row(12'h000, 1'b0);
		done("rows");
		// A load strobe while the enable is low must leave the register alone
		isc_ctrl_model_inst.write_reg(4'h2, 12'h0A5);
		ce <= 1'b0;
		isc_ctrl_model_inst.write_reg(4'h2, 12'h5A5);
		ce <= 1'b1;
		read_reg(4'h2, 12'h0A5);
		check("frozen line count", line_count, 12'h0A5);
		done("enable");
		close_out();
	end
endmodule
